// ### regfile_decode.sv
// Function
// - Decode a 12-bit 4096-byte address space
// - F00H to FFFH goes to control registers
// - Unimplemented control reads return any value
// - RAM starts at 000H, 256 B to 1 KB
// - Reads between RAM and control are undefined
// - Writes between RAM and control are dropped
// - Read sources, write destinations during execution
// - All RAM bytes interchangeable, none specialised
// - Shared pin powers up as reset, large package
/*
 Register file address decoder for an 8-bit core, with the shared
 reset/port pin mode logic. Assumes the core holds each request for one
 cycle and takes read data two cycles later; control registers live in
 the peripherals, which answer on ctrl_rdata_i with ctrl_hit_i.
*/
`timescale 1ns/10ps
`include "regfile_map.svh"

module regfile_decode #(
   parameter int RAM_BYTES   = `RF_RAM_MAX_BYTES, // Implemented RAM size
   parameter bit SMALL_PKG   = 1'b0               // Smallest package variant
) (
   input  wire logic                   clk_i,          // System clock
   input  wire logic                   rst_b_i,        // Sync reset, low
   input  wire logic                   rd_en_i,        // Source read request
   input  wire logic                   wr_en_i,        // Destination write
   input  wire logic [`RF_ADDR_W-1:0]  addr_i,         // Byte address
   input  wire logic [`RF_DATA_W-1:0]  wdata_i,        // Write data
   input  wire logic [`RF_DATA_W-1:0]  ctrl_rdata_i,   // Control read data
   input  wire logic                   ctrl_hit_i,     // Control reg present
   input  wire logic                   pin_mode_wr_i,  // Write pin mode
   input  wire logic                   pin_mode_i,     // 1 reset, 0 port
   input  wire logic                   port_cfg_wr_i,  // Write port config
   input  wire logic                   port_pull_i,    // Port pull-up enable
   input  wire logic                   port_od_i,      // Port open-drain
   input  wire logic                   port_out_i,     // Port output value
   input  wire logic                   port_oe_i,      // Port drive enable
   input  wire logic                   int_reset_i,    // Chip in reset
   input  wire logic                   pin_in_i,       // Shared pin level
   output logic [`RF_DATA_W-1:0]       rdata_o,        // Read data
   output logic                        rvalid_o,       // Read data valid
   output logic                        ctrl_sel_o,     // Control strobe
   output logic                        ctrl_wr_o,      // Control write
   output logic [7:0]                  ctrl_addr_o,    // Control offset
   output logic [`RF_DATA_W-1:0]       ctrl_wdata_o,   // Control wdata
   output logic                        pin_out_o,      // Shared pin output
   output logic                        pin_oe_o,       // Shared pin enable
   output logic                        pin_pull_o,     // Pull-up on
   output logic                        pin_is_reset_o, // Pin in reset mode
   output logic                        ext_reset_o,    // Reset seen on pin
   output logic                        port_in_o       // Port input bit
);
   localparam int AW = $clog2(RAM_BYTES);

   // =================================================================
   // Region decode; the control test comes first, so the top 256 bytes
   // stay control space whatever RAM size is chosen, and the gap is
   // whatever lies between the end of RAM and the control region
   function automatic regfile_pkg::region_e region_of(
      input logic [`RF_ADDR_W-1:0] a
   );
      if (a[`RF_ADDR_W-1 -: 4] == `RF_CTRL_TAG) begin
         region_of = regfile_pkg::region_ctrl;
      end else if (a < `RF_ADDR_W'(RAM_BYTES)) begin
         region_of = regfile_pkg::region_ram;
      end else begin
         region_of = regfile_pkg::region_gap;
      end
   endfunction : region_of

   // Request decode; only RAM-region writes reach the store, since the
   // store keeps just the low address bits and a gap address would alias
   regfile_pkg::region_e  region;
   wire                   ram_wr;
   wire                   ctrl_acc;
   assign region   = region_of(addr_i);
   assign ram_wr   = wr_en_i && (region == regfile_pkg::region_ram);
   assign ctrl_acc = (rd_en_i || wr_en_i) && (region == regfile_pkg::region_ctrl);

   // =================================================================
   // RAM store
   // The store reads every cycle; the result counts only for a RAM read
   regfile_if #(.RAM_BYTES(RAM_BYTES)) ram_bus ();
   assign ram_bus.wr_en = ram_wr;
   assign ram_bus.addr  = addr_i[AW-1:0];
   assign ram_bus.wdata = wdata_i;

   gp_ram_store #(.RAM_BYTES(RAM_BYTES)) u_store (
      .clk_i (clk_i),
      .bus   (ram_bus)
   );

   // Region and read flag held for the data cycle
   // The region is held because addr_i may already carry the next request
   regfile_pkg::region_e rd_region;
   logic                 rd_pend;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rd_pend   <= 1'b0;
         rd_region <= regfile_pkg::region_gap;
      end else begin
         rd_pend   <= rd_en_i;
         rd_region <= region;
      end
   end

   // Read data select; gap and absent registers give a fixed filler
   // The peripheral answers on ctrl_hit_i in the strobe cycle itself,
   // the same cycle in which rd_pend stands, so no extra stage is needed
   wire [`RF_DATA_W-1:0] next_rdata;
   assign next_rdata =
      (rd_region == regfile_pkg::region_ram)  ? ram_bus.rdata :
      (rd_region == regfile_pkg::region_ctrl && ctrl_hit_i) ? ctrl_rdata_i :
      `RF_UNDEF_DATA;

   // Read answer and control strobes; writes to absent control
   // registers are passed on, the caller must not issue them
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rdata_o      <= '0;
         rvalid_o     <= 1'b0;
         ctrl_sel_o   <= 1'b0;
         ctrl_wr_o    <= 1'b0;
         ctrl_addr_o  <= '0;
         ctrl_wdata_o <= '0;
      end else begin
         rvalid_o     <= rd_pend;
         rdata_o      <= rd_pend ? next_rdata : rdata_o;
         ctrl_sel_o   <= ctrl_acc;
         ctrl_wr_o    <= ctrl_acc && wr_en_i;
         ctrl_addr_o  <= addr_i[7:0];
         ctrl_wdata_o <= wdata_i;
      end
   end

   // =================================================================
   // Shared reset/port pin
   logic pin_mode;
   logic port_pull;
   logic port_od;
   logic sync_a;
   logic sync_b;
   logic sync_c;
   logic pin_level;

   // Mode and port configuration; power-up in reset mode
   // Port settings load in reset mode too, so they are ready at the switch
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_mode  <= `PIN_MODE_RESET_VAL;
         port_pull <= 1'b0;
         port_od   <= 1'b0;
      end else begin
         if (pin_mode_wr_i) begin
            pin_mode <= pin_mode_i;
         end
         if (port_cfg_wr_i) begin
            port_pull <= port_pull_i;
            port_od   <= port_od_i;
         end
      end
   end

   // Three-stage input sync; level changes when stages two and three agree
   // One metastable first-stage sample can never pass as a pin edge,
   // because two later stages must agree before the level moves
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sync_a    <= 1'b1;
         sync_b    <= 1'b1;
         sync_c    <= 1'b1;
         pin_level <= 1'b1;
      end else begin
         sync_a    <= pin_in_i;
         sync_b    <= sync_a;
         sync_c    <= sync_b;
         pin_level <= (sync_b == sync_c) ? sync_c : pin_level;
      end
   end

   // Pin drive: reset mode forces open-drain low and pull-up on
   // In port mode with open-drain set, a high is left to the pull-up and
   // only a low is driven; reset mode drives low while the chip is in reset
   wire drive_low_reset;
   wire next_oe;
   wire next_out;
   wire next_pull;
   assign drive_low_reset = int_reset_i;
   assign next_oe   = pin_mode ? drive_low_reset :
                      (port_od ? (port_oe_i && !port_out_i) : port_oe_i);
   assign next_out  = pin_mode ? 1'b0 : port_out_i;
   assign next_pull = pin_mode ? 1'b1 : port_pull;

   // Registered pin outputs and status
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_oe_o       <= 1'b0;
         pin_out_o      <= 1'b0;
         pin_pull_o     <= 1'b1;
         pin_is_reset_o <= 1'b1;
         ext_reset_o    <= 1'b0;
         port_in_o      <= 1'b1;
      end else begin
         pin_oe_o       <= next_oe;
         pin_out_o      <= next_out;
         pin_pull_o     <= next_pull;
         pin_is_reset_o <= pin_mode;
         ext_reset_o    <= pin_mode && !pin_level;
         port_in_o      <= pin_level;
      end
   end

   // SMALL_PKG selects the same forcing on the smallest package's pin
   // Kept so the package variant shows at the instance; no logic differs
   wire unused_pkg;
   assign unused_pkg = SMALL_PKG;
endmodule : regfile_decode

// ### regfile_map.svh
/*
 Constants of the register file decoder: address widths, region bounds,
 reset values of the shared reset/port pin logic.
 Assumes it is included by its bare name.
*/
`ifndef REGFILE_MAP_SVH
`define REGFILE_MAP_SVH

// =====================================================================
// Address space
`define RF_ADDR_W        12
`define RF_SPACE_BYTES   4096
`define RF_CTRL_BASE     12'hf00
`define RF_CTRL_LAST     12'hfff
`define RF_CTRL_TAG      4'hf
`define RF_RAM_BASE      12'h000
`define RF_RAM_MIN_BYTES 256
`define RF_RAM_MAX_BYTES 1024
`define RF_DATA_W        8
`define RF_UNDEF_DATA    8'hff

// =====================================================================
// Shared pin reset values
`define PIN_MODE_RESET_VAL 1'b1
`define PIN_PORT_OUT_RESET 1'b1

`endif

// ### regfile_pkg.sv
/*
 Types used by the register file decoder; the access carrier uses none.
 Assumes regfile_map.svh constants are used for all figures.
*/
package regfile_pkg;

   // Region selected by one access
   typedef enum logic [1:0] {
      region_ram,
      region_gap,
      region_ctrl
   } region_e;

   // Mode of the shared reset/port pin
   typedef enum logic {
      pin_port,
      pin_reset
   } pin_mode_e;

endpackage : regfile_pkg

// ### regfile_if.sv
/*
 Carrier between the decoder and the general-purpose RAM store.
 Assumes one clock shared by both sides.
*/
`timescale 1ns/10ps
`include "regfile_map.svh"

interface regfile_if #(
   parameter int RAM_BYTES = `RF_RAM_MAX_BYTES
);
   localparam int AW = $clog2(RAM_BYTES);

   logic                  wr_en;
   logic [AW-1:0]         addr;
   logic [`RF_DATA_W-1:0] wdata;
   logic [`RF_DATA_W-1:0] rdata;

   modport ctrl (output wr_en, output addr, output wdata, input rdata);
   modport store (input wr_en, input addr, input wdata, output rdata);
endinterface : regfile_if

// ### gp_ram_store.sv
/*
 General-purpose register storage: flat byte array, one read and one
 write port, synchronous read. Assumes decoded, in-range accesses only.
*/
`timescale 1ns/10ps
`include "regfile_map.svh"

module gp_ram_store #(
   parameter int RAM_BYTES = `RF_RAM_MAX_BYTES
) (
   input  wire logic clk_i,   // System clock
   regfile_if.store  bus      // Decoded RAM access
);
   // =================================================================
   // Storage
   logic [`RF_DATA_W-1:0] mem [RAM_BYTES];

   // Write and registered read; no location is special
   always_ff @(posedge clk_i) begin
      if (bus.wr_en) begin
         mem[bus.addr] <= bus.wdata;
      end
      bus.rdata <= mem[bus.addr];
   end
endmodule : gp_ram_store

// ### regfile_decode_chk.sv
/* Checker for regfile_decode: access timing, region steering, pin mode.
   Assumes it is bound to every regfile_decode instance. */
`timescale 1ns/10ps
`include "regfile_map.svh"

module regfile_decode_chk #(
   parameter int RAM_BYTES = `RF_RAM_MAX_BYTES // RAM size
) (
   input wire logic                  clk_i,          // Clock
   input wire logic                  rst_b_i,        // Reset
   input wire logic                  rd_en_i,        // Read
   input wire logic                  wr_en_i,        // Write
   input wire logic [`RF_ADDR_W-1:0] addr_i,         // Address
   input wire logic [`RF_DATA_W-1:0] wdata_i,        // Wdata
   input wire logic [`RF_DATA_W-1:0] ctrl_rdata_i,   // Ctrl data
   input wire logic                  ctrl_hit_i,     // Ctrl hit
   input wire logic [`RF_DATA_W-1:0] rdata_o,        // Rdata
   input wire logic                  rvalid_o,       // Valid
   input wire logic                  ctrl_sel_o,     // Ctrl strobe
   input wire logic                  ctrl_wr_o,      // Ctrl write
   input wire logic [7:0]            ctrl_addr_o,    // Ctrl offset
   input wire logic [`RF_DATA_W-1:0] ctrl_wdata_o,   // Ctrl wdata
   input wire logic                  pin_out_o,      // Pin out
   input wire logic                  pin_oe_o,       // Pin enable
   input wire logic                  pin_pull_o,     // Pull-up
   input wire logic                  pin_is_reset_o  // Reset mode
);
   // =================================================================
   // Decode helpers
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire ctl = addr_i[11:8] == `RF_CTRL_TAG;
   wire gap = 32'(addr_i) >= RAM_BYTES && !ctl;
   sequence s_answer; ##2 rvalid_o; endsequence
   sequence s_ctrl_req; (rd_en_i || wr_en_i) && ctl; endsequence

   // =================================================================
   // Properties
   property p_rd_lat; rd_en_i |-> s_answer; endproperty
   property p_cause; rvalid_o |-> $past(rd_en_i, 2); endproperty
   property p_gap_rd; rd_en_i && gap |-> s_answer ##0 rdata_o == `RF_UNDEF_DATA; endproperty
   property p_sel; s_ctrl_req |=> ctrl_sel_o && ctrl_addr_o == $past(addr_i[7:0]); endproperty
   property p_no_sel; !((rd_en_i || wr_en_i) && ctl) |=> !ctrl_sel_o; endproperty
   property p_ctrl_wr; wr_en_i && ctl |=> ctrl_wr_o && ctrl_wdata_o == $past(wdata_i); endproperty
   property p_ctrl_rd;
      ctrl_sel_o && !ctrl_wr_o |=>
         rdata_o == ($past(ctrl_hit_i) ? $past(ctrl_rdata_i) : `RF_UNDEF_DATA);
   endproperty
   property p_boot;
      disable iff (1'b0) !rst_b_i |=> pin_is_reset_o && pin_pull_o && !pin_oe_o;
   endproperty
   property p_force; pin_is_reset_o |-> pin_pull_o && !(pin_oe_o && pin_out_o); endproperty

   a_rd_lat: assert property (p_rd_lat) else $error("read not answered in 2");
   a_cause: assert property (p_cause) else $error("valid without read");
   a_gap_rd: assert property (p_gap_rd) else $error("gap read data");
   a_sel: assert property (p_sel) else $error("control strobe missing");
   a_no_sel: assert property (p_no_sel) else $error("stray control strobe");
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read data");
   a_boot: assert property (p_boot) else $error("pin not reset mode");
   a_force: assert property (p_force) else $error("reset pin not forced");
endmodule : regfile_decode_chk

bind regfile_decode regfile_decode_chk #(.RAM_BYTES(RAM_BYTES)) regfile_decode_chk_i (
   .clk_i, .rst_b_i, .rd_en_i, .wr_en_i, .addr_i, .wdata_i, .ctrl_rdata_i, .ctrl_hit_i,
   .rdata_o, .rvalid_o, .ctrl_sel_o, .ctrl_wr_o, .ctrl_addr_o, .ctrl_wdata_o,
   .pin_out_o, .pin_oe_o, .pin_pull_o, .pin_is_reset_o);

// ### ctrl_periph_model.sv
/* Control-register peripheral model answering in the strobe cycle.
   Assumes implemented registers sit at even offsets only. */
`timescale 1ns/10ps

module ctrl_periph_model (
   input  wire logic       clk_i,  // Clock
   input  wire logic       sel_i,  // Strobe
   input  wire logic [7:0] addr_i, // Offset
   output logic            hit_o,  // Present
   output logic [7:0]      rdata_o // Data
);
   logic [7:0] junk = 8'h00;
   // Moving pattern while nothing answers
   always @(posedge clk_i) junk <= junk + 8'h3b;
   // Present registers answer with a function of the offset
   assign hit_o   = sel_i && !addr_i[0];
   assign rdata_o = hit_o ? (addr_i ^ 8'h5a) : junk;
endmodule : ctrl_periph_model

// ### register_file_address_decode_tb.sv
/* Bench for regfile_decode: pin mode, boundary and random accesses.
   Assumes ctrl_periph_model serves control reads. */
`timescale 1ns/10ps
`include "regfile_map.svh"

module register_file_address_decode_tb;
   localparam int RB = 512;
   logic        clk_i, rst_b_i = 0, rd_en_i = 0, wr_en_i = 0, ctrl_hit_i, pin_mode_wr_i = 0;
   logic        pin_mode_i = 1, port_cfg_wr_i = 0, port_pull_i = 1, port_od_i = 1;
   logic        port_out_i = 0, port_oe_i = 0, int_reset_i = 0, pin_in_i = 1, rvalid_o;
   logic        ctrl_sel_o, ctrl_wr_o, pin_out_o, pin_oe_o, pin_pull_o, pin_is_reset_o;
   logic        ext_reset_o, port_in_o;
   logic [11:0] addr_i = 0;
   logic [7:0]  wdata_i = 0, ctrl_rdata_i, rdata_o, ctrl_addr_o, ctrl_wdata_o;
   logic [7:0]  mem [RB];
   logic [7:0]  expq [$];
   logic [11:0] edges [8] = '{0, 12'(RB - 1), 12'(RB), 12'(RB + 1), 12'heff, 12'hf00,
                              12'hf01, 12'hfff};
   integer      seed = 32'hac24d79f;
   int          miscompares = 0, n_compared = 0, k;
   bit          m_mode, m_pull, m_od, e_oe, e_out, e_pull, e_rst, e_ext, e_in;
   bit          f1, f2, f3, f_lvl;

   regfile_decode #(.RAM_BYTES(RB)) regfile_decode_i (.clk_i, .rst_b_i, .rd_en_i, .wr_en_i,
      .addr_i, .wdata_i, .ctrl_rdata_i, .ctrl_hit_i, .pin_mode_wr_i, .pin_mode_i,
      .port_cfg_wr_i, .port_pull_i, .port_od_i, .port_out_i, .port_oe_i, .int_reset_i,
      .pin_in_i, .rdata_o, .rvalid_o, .ctrl_sel_o, .ctrl_wr_o, .ctrl_addr_o, .ctrl_wdata_o,
      .pin_out_o, .pin_oe_o, .pin_pull_o, .pin_is_reset_o, .ext_reset_o, .port_in_o);
   ctrl_periph_model ctrl_periph_model_i (.clk_i, .sel_i(ctrl_sel_o), .addr_i(ctrl_addr_o),
      .hit_o(ctrl_hit_i), .rdata_o(ctrl_rdata_i));

   // =================================================================
   // Clock, checks, model
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask : chk8
   task chk1(input string nm, input logic e, input logic s);
      chk8(nm, {7'h00, e}, {7'h00, s});
   endtask : chk1
   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   function automatic logic [7:0] expect_rd(input logic [11:0] a);
      if (a < RB) return mem[a];
      if (a[11:8] == `RF_CTRL_TAG && !a[0]) return a[7:0] ^ 8'h5a;
      return `RF_UNDEF_DATA;
   endfunction : expect_rd
   // One access per cycle, back to back
   task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      logic [11:0] b;
      b = (w && a[11:8] == `RF_CTRL_TAG) ? {a[11:1], 1'b0} : a;
      if (w && b < RB) mem[b] = d;
      if (!w) expq.push_back(expect_rd(b));
      rd_en_i <= !w;
      wr_en_i <= w;
      addr_i  <= b;
      wdata_i <= d;
      @(posedge clk_i);
   endtask : acc
   // Write pin mode and port settings in one pulse, then let them settle
   task pin_cfg(input logic md, input logic pu, input logic od);
      @(posedge clk_i);
      pin_mode_i    <= md;
      port_pull_i   <= pu;
      port_od_i     <= od;
      pin_mode_wr_i <= 1'b1;
      port_cfg_wr_i <= 1'b1;
      @(posedge clk_i);
      pin_mode_wr_i <= 1'b0;
      port_cfg_wr_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
   endtask : pin_cfg
   // Every read answer against the model
   always @(negedge clk_i)
      if (rst_b_i && rvalid_o !== 1'b0) begin
         if (expq.size() == 0) chk1("spare rvalid", 1'b0, rvalid_o);
         else chk8("rdata", expq.pop_front(), rdata_o);
      end
   // Random levels on the port side of the pin
   always @(posedge clk_i) {port_out_i, port_oe_i, int_reset_i, pin_in_i} <= 4'($random(seed));
   // Pin model: settings as written, three-stage filter on the pin level
   always @(posedge clk_i)
      if (!rst_b_i) begin
         {m_mode, m_pull, m_od, e_oe, e_out} = 5'h10;
         {e_pull, e_rst, e_ext, e_in} = 4'hd;
         {f1, f2, f3, f_lvl} = 4'hf;
      end else begin
         e_oe   = m_mode ? int_reset_i : (m_od ? (port_oe_i && !port_out_i) : port_oe_i);
         e_out  = !m_mode && port_out_i;
         e_pull = m_mode || m_pull;
         e_rst  = m_mode;
         e_ext  = m_mode && !f_lvl;
         e_in   = f_lvl;
         if (f2 == f3) f_lvl = f3;
         f3 = f2;
         f2 = f1;
         f1 = pin_in_i;
         if (pin_mode_wr_i) m_mode = pin_mode_i;
         if (port_cfg_wr_i) {m_pull, m_od} = {port_pull_i, port_od_i};
      end
   // Every pin output against the model, once per cycle
   always @(negedge clk_i)
      if (rst_b_i) begin
         chk1("pin_oe", e_oe, pin_oe_o);
         chk1("pin_out", e_out, pin_out_o);
         chk1("pin_pull", e_pull, pin_pull_o);
         chk1("pin_is_reset", e_rst, pin_is_reset_o);
         chk1("ext_reset", e_ext, ext_reset_o);
         chk1("port_in", e_in, port_in_o);
      end
   // Cut a hang short
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      end_sim();
   end

   // =================================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
      chk1("reset mode", 1'b1, pin_is_reset_o);
      chk1("pull forced", 1'b1, pin_pull_o);
      pin_cfg(1'b0, 1'b0, 1'b1);
      chk1("pull programmable off", 1'b0, pin_pull_o);
      chk1("port mode", 1'b0, pin_is_reset_o);
      pin_cfg(1'b0, 1'b1, 1'b0);
      chk1("pull programmable on", 1'b1, pin_pull_o);
      pin_cfg(1'b1, 1'b0, 1'b1);
      chk1("pull forced again", 1'b1, pin_pull_o);
      chk1("reset mode again", 1'b1, pin_is_reset_o);
      $display("test pin done");
      @(posedge clk_i);
      for (k = 0; k < RB; k++) acc(1'b1, 12'(k), 8'($random(seed)));
      foreach (edges[i]) begin
         acc(1'b1, edges[i], ~edges[i][7:0]);
         acc(1'b0, edges[i], 8'h00);
         acc(1'b0, 12'(edges[i] % RB), 8'h00);
      end
      $display("test edges done");
      for (k = 0; k < 300; k++) acc(1'($random(seed)), 12'($random(seed)), 8'($random(seed)));
      rd_en_i <= 1'b0;
      wr_en_i <= 1'b0;
      for (k = 0; k < 16 && expq.size() > 0; k++) @(posedge clk_i);
      chk1("all reads answered", 1'b1, expq.size() == 0);
      $display("test random done");
      end_sim();
   end
endmodule : register_file_address_decode_tb
